// [rx_lsr_pkg.sv]
// package: constants, register map and types for the receive line status block
package rx_lsr_pkg;
  // character storage
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] FIFO_CAP = 6'h20;
  localparam logic [CNT_W-1:0] HOLD_CAP = 6'h01;
  // register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_RX_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LINE_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RX_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h10;
  // receive_line_status bit positions (also event bit positions)
  localparam int BIT_DATA_READY = 0;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_PARITY_ERR = 2;
  localparam int BIT_FRAMING_ERR = 3;
  localparam int EV_W = 4;
  // control register bit positions and reset value
  localparam int BIT_FIFO_EN = 0;
  localparam int BIT_PARITY_EN = 1;
  localparam int BIT_PARITY_EVEN = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam logic [EV_W-1:0] EV_RESET = 4'h0;
  // axi4-lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one stored character with its own error tags
  typedef struct packed {
    logic framing_err;
    logic parity_err;
    logic [DATA_W-1:0] data;
  } rx_entry_t;
endpackage

// [rx_char_fifo.sv]
// module: flip-flop receive character store with per-entry error tags
`timescale 1ns/1ps
`default_nettype none
module rx_char_fifo
  import rx_lsr_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // control
  input wire logic flush_i,
  input wire logic push_i,
  input wire rx_entry_t push_entry_i,
  input wire logic pop_i,
  // status
  output rx_entry_t head_o,
  output logic [CNT_W-1:0] count_o
);
  rx_entry_t mem_reg [FIFO_DEPTH];
  rx_entry_t mem_next [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic do_push, do_pop;

  // caller guarantees push only while not full, pop only while not empty
  always_comb begin
    do_push = push_i && !flush_i;
    do_pop = pop_i && !flush_i && (count_reg != '0);
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (flush_i) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
    end else begin
      if (do_push) begin
        mem_next[wr_ptr_reg] = push_entry_i;
        wr_ptr_next = wr_ptr_reg + 5'h01;
      end
      if (do_pop) begin
        rd_ptr_next = rd_ptr_reg + 5'h01;
      end
      if (do_push && !do_pop) begin
        count_next = count_reg + 6'h01;
      end else if (do_pop && !do_push) begin
        count_next = count_reg - 6'h01;
      end
    end
  end

  // pointers reset; storage needs no reset since count gates it
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    mem_reg <= mem_next;
  end

  assign head_o = mem_reg[rd_ptr_reg];
  assign count_o = count_reg;
endmodule
`default_nettype wire

// [rx_line_status.sv]
// module: receive line status flags, receive store and axi4-lite register slave
// register map, one 32-bit word each, byte offsets from the package:
//   rx data       read pops the head character; empty reads return zero
//   line status   data ready, overrun, head parity and framing tags
//   control       fifo enable, parity enable, even parity select
//   int status    sticky events, write one to clear, set beats clear
//   int mask      same layout as int status
// control bits: 0 fifo enable (depth 32, else one holding slot),
//   1 parity check enable, 2 even parity (else odd)
// event bits: 0 character stored, 1 overrun, 2 stored character failed
//   parity, 3 stored character lacked its stop bit
// status bits 7:4 read as zero; transmit and break status live elsewhere
// irq is high while any unmasked event bit is set; status reads keep it
//
// bus: write address and data are taken together at one edge, a read
// address alone; each answer rises one edge later and stands until its
// ready. unmapped offsets answer slverr, read zero and change nothing.
//
// timing: a character lands in the shift register at its done edge and
// is stored one edge later, so a read taken two edges after done sees it.
// limitation: the full test ignores a same-cycle pop, so a read that
// frees room in the very cycle a character is judged does not save it.
// a mode switch flushes the store and drops a character pending then,
// without raising overrun; software should switch modes while idle.
// reset empties the store and leaves holding mode with parity off.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rx_line_status
  import rx_lsr_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // finished characters from the deserialiser (same clock)
  input wire logic rx_char_done_i,
  input wire logic [DATA_W-1:0] rx_char_data_i,
  input wire logic rx_char_parity_i,
  input wire logic rx_char_stop_i,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq_o
);

  // receive path state
  rx_entry_t shift_reg, shift_next;
  logic pending_reg, pending_next;
  logic overrun_reg, overrun_next;
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [EV_W-1:0] int_status_reg, int_status_next;
  logic [EV_W-1:0] int_mask_reg, int_mask_next;
  // bus state
  // responses come from flip-flops; only the ready signals are combinational
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  // store interface
  rx_entry_t head;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] capacity;
  logic store_full, push, pop, flush;

  // bus decode
  logic wr_take, rd_take, lsr_read;
  logic [31:0] wmask;
  logic [31:0] wdata_m;

  // status word and one-cycle event pulses
  logic data_ready;
  logic [7:0] line_status;
  logic [EV_W-1:0] events;

  // the store trusts its caller: push only with room, pop only with data
  // count is the fill level; capacity below decides how much of it is usable
  rx_char_fifo store (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .flush_i(flush),
    .push_i(push),
    .push_entry_i(shift_reg),
    .pop_i(pop),
    .head_o(head),
    .count_o(count)
  );

  // holding register mode is simply a store of depth one
  always_comb begin
    capacity = ctrl_reg[BIT_FIFO_EN] ? FIFO_CAP : HOLD_CAP;
    // >= so a shrunk capacity can never let a push through
    store_full = (count >= capacity);
    data_ready = (count != '0);
    // bits 7:4 belong to transmit and break status kept elsewhere, read zero
    // tags only mean something while a character is at the head
    line_status = 8'h00;
    line_status[BIT_DATA_READY] = data_ready;
    line_status[BIT_OVERRUN] = overrun_reg;
    line_status[BIT_PARITY_ERR] = data_ready && head.parity_err;
    line_status[BIT_FRAMING_ERR] = data_ready && head.framing_err;
  end

  // bus handshakes: write takes address and data together, one at a time
  // no skid buffer: a lone address or data beat simply waits
  // a read is refused while its previous answer still stands
  always_comb begin
    wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
    rd_take = s_axi_arvalid && !rvalid_reg;
    s_axi_awready = wr_take;
    s_axi_wready = wr_take;
    s_axi_arready = rd_take;
    lsr_read = rd_take && (s_axi_araddr == OFF_LINE_STATUS);
    pop = rd_take && (s_axi_araddr == OFF_RX_DATA) && data_ready;
    wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wdata_m = s_axi_wdata & wmask;
  end

  // receive path: capture, then transfer one cycle later unless full
  always_comb begin
    shift_next = shift_reg;
    // pending lasts one cycle: the edge after capture decides store or overrun
    pending_next = 1'b0;
    // transfer only with room; otherwise the character is lost and the
    // stored ones stay untouched
    push = pending_reg && !store_full && !flush;
    overrun_next = overrun_reg;
    events = EV_RESET;
    if (rx_char_done_i) begin
      // a newer character always replaces the shift contents
      shift_next.data = rx_char_data_i;
      shift_next.framing_err = !rx_char_stop_i;
      // parity covers all eight data bits plus the received parity bit
      shift_next.parity_err = ctrl_reg[BIT_PARITY_EN]
        && ((^{rx_char_data_i, rx_char_parity_i}) ^ !ctrl_reg[BIT_PARITY_EVEN]);
      pending_next = 1'b1;
    end
    // cleared by a status read; a new overrun in that cycle still wins
    if (lsr_read) begin
      overrun_next = 1'b0;
    end
    if (pending_reg && store_full && !flush) begin
      overrun_next = 1'b1;
      events[BIT_OVERRUN] = 1'b1;
    end
    // event pulses carry the tags of the character entering the store
    if (push) begin
      events[BIT_DATA_READY] = 1'b1;
      events[BIT_PARITY_ERR] = shift_reg.parity_err;
      events[BIT_FRAMING_ERR] = shift_reg.framing_err;
    end
  end

  // register writes; the line status offset has no write target
  always_comb begin
    ctrl_next = ctrl_reg;
    int_mask_next = int_mask_reg;
    int_status_next = int_status_reg;
    // flush is a one-cycle pulse, raised only by a mode change
    flush = 1'b0;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    if (wr_take) begin
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      unique case (s_axi_awaddr)
        // a write without byte lane 0 leaves control alone
        OFF_RX_CTRL: begin
          if (s_axi_wstrb[0]) begin
            ctrl_next = s_axi_wdata[CTRL_W-1:0];
            // mode change discards stored characters
            flush = (s_axi_wdata[BIT_FIFO_EN] != ctrl_reg[BIT_FIFO_EN]);
          end
        end
        OFF_INT_MASK: begin
          if (s_axi_wstrb[0]) begin
            int_mask_next = s_axi_wdata[EV_W-1:0];
          end
        end
        // only bits under a set strobe are cleared
        OFF_INT_STATUS: begin
          int_status_next = int_status_reg & ~wdata_m[EV_W-1:0];
        end
        OFF_LINE_STATUS, OFF_RX_DATA: begin
          bresp_next = RESP_OKAY;
        end
        default: begin
          bresp_next = RESP_SLVERR;
        end
      endcase
    end
    // set after clear so an event in the clearing cycle is kept
    int_status_next = int_status_next | events;
  end

  // read data mux, registered into the response
  always_comb begin
    // rvalid drops at the edge that finds rready
    rvalid_next = rvalid_reg && !s_axi_rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (rd_take) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h0000_0000;
      // rx data returns the head as it stands at the taking edge
      unique case (s_axi_araddr)
        OFF_RX_DATA: rdata_next = {24'h000000, data_ready ? head.data : 8'h00};
        OFF_LINE_STATUS: rdata_next = {24'h000000, line_status};
        OFF_RX_CTRL: rdata_next = {29'h0, ctrl_reg};
        OFF_INT_STATUS: rdata_next = {28'h0000000, int_status_reg};
        OFF_INT_MASK: rdata_next = {28'h0000000, int_mask_reg};
        default: rresp_next = RESP_SLVERR;
      endcase
    end
  end

  // receive path registers; the shift register is reset so stale tags
  // can never leak into a status read
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_reg <= '0;
      pending_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      pending_reg <= pending_next;
      overrun_reg <= overrun_next;
    end
  end

  // control, interrupt and write response registers; reset leaves
  // holding mode, parity off and every event masked
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= CTRL_RESET;
      int_status_reg <= EV_RESET;
      int_mask_reg <= EV_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      ctrl_reg <= ctrl_next;
      int_status_reg <= int_status_next;
      int_mask_reg <= int_mask_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // read response registers; rdata is held until the edge that finds rready
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  // a level of registered bits only, so bus inputs cannot glitch it
  assign irq_o = |(int_status_reg & int_mask_reg);
endmodule
`default_nettype wire

// [rx_line_status_props.sv]
// checker: port-level properties of the receive line status block
`timescale 1ns/1ps
`default_nettype none
module rx_line_status_props
  import rx_lsr_pkg::*;
(
  // clock, reset, characters
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic rx_char_done_i,
  input wire logic rx_char_stop_i,
  // register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  input wire logic irq_o
);
  logic [ADDR_W-1:0] ra_reg;
  logic [ADDR_W-1:0] wa_reg;
  logic any_reg;
  logic bad_reg;
  logic lsr_rd;
  // taken addresses and character history; history is sticky, so checks stay conservative
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ra_reg <= '0;
      wa_reg <= '0;
      any_reg <= 1'b0;
      bad_reg <= 1'b0;
    end else begin
      if (s_axi_arvalid && !s_axi_rvalid) ra_reg <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) wa_reg <= s_axi_awaddr;
      if (rx_char_done_i) any_reg <= 1'b1;
      if (rx_char_done_i && !rx_char_stop_i) bad_reg <= 1'b1;
    end
  end
  assign lsr_rd = s_axi_rvalid && (ra_reg == OFF_LINE_STATUS);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  property p_quiet; lsr_rd && !any_reg |-> s_axi_rdata[3:0] == 4'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("status not clear");
  property p_frame; lsr_rd && !bad_reg |-> !s_axi_rdata[3]; endproperty
  a_frame: assert property (p_frame) else $error("framing flag without cause");
  property p_empty; lsr_rd && !s_axi_rdata[0] |-> s_axi_rdata[3:2] == 2'h0; endproperty
  a_empty: assert property (p_empty) else $error("error tags while empty");
  property p_upper; lsr_rd |-> s_axi_rdata[31:4] == 28'h0; endproperty
  a_upper: assert property (p_upper) else $error("status upper bits set");
  property p_ro; s_axi_bvalid && wa_reg == OFF_LINE_STATUS |-> s_axi_bresp == RESP_OKAY;
  endproperty
  a_ro: assert property (p_ro) else $error("status write refused");
  // answer stands until rready, then drops at that very edge
  property p_hold; s_axi_rvalid |=>
    ($past(s_axi_rready) ? !s_axi_rvalid : (s_axi_rvalid && $stable(s_axi_rdata)));
  endproperty
  a_hold: assert property (p_hold) else $error("read data dropped");
  property p_irq; !any_reg |-> !irq_o; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without event");
  property p_unmap; s_axi_rvalid && ra_reg > OFF_INT_MASK |->
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  c_ovr: cover property (lsr_rd && s_axi_rdata[1]);
  c_frm: cover property (lsr_rd && s_axi_rdata[3]);
  c_irq: cover property (irq_o);
endmodule
bind rx_line_status rx_line_status_props props_i (.mclk_i, .rst_b_i, .rx_char_done_i,
  .rx_char_stop_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .irq_o);
`default_nettype wire

// [rx_char_source.sv]
// model: remote transmitter, one finished character per pulse, odd parity
`timescale 1ns/1ps
`default_nettype none
module rx_char_source
  import rx_lsr_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // request from the bench
  input wire logic send_i,
  input wire logic [DATA_W-1:0] byte_i,
  input wire logic bad_par_i,
  input wire logic bad_stop_i,
  // character towards the block
  output logic done_o,
  output logic [DATA_W-1:0] data_o,
  output logic par_o,
  output logic stop_o
);
  // outside a pulse the lines toggle, so a stale value is never mistaken for data
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
      data_o <= '0;
      par_o <= 1'b0;
      stop_o <= 1'b0;
    end else if (send_i) begin
      done_o <= 1'b1;
      data_o <= byte_i;
      par_o <= ~^byte_i ^ bad_par_i;
      stop_o <= ~bad_stop_i;
    end else begin
      done_o <= 1'b0;
      data_o <= ~data_o;
      par_o <= ~par_o;
      stop_o <= ~stop_o;
    end
  end
endmodule
`default_nettype wire

// [test_uart_rx_line_status_flags.sv]
// testbench: register-level tests of the receive line status block
`timescale 1ns/1ps
`default_nettype none
module test_uart_rx_line_status_flags;
  import rx_lsr_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic send = 1'b0;
  logic bp = 1'b0;
  logic bs = 1'b0;
  logic [7:0] tb = 8'h00;
  logic rx_char_done_i, rx_char_parity_i, rx_char_stop_i;
  logic [7:0] rx_char_data_i;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, got;
  int fails = 0;
  int total_checks = 0;
  int i;
  // free-running bench clock
  always #20 mclk_i = ~mclk_i;
  rx_char_source src (.mclk_i, .rst_b_i, .send_i(send), .byte_i(tb), .bad_par_i(bp),
    .bad_stop_i(bs), .done_o(rx_char_done_i), .data_o(rx_char_data_i),
    .par_o(rx_char_parity_i), .stop_o(rx_char_stop_i));
  rx_line_status dut (.mclk_i, .rst_b_i, .rx_char_done_i, .rx_char_data_i, .rx_char_parity_i,
    .rx_char_stop_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq_o);
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // write: address and data offered together, bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge mclk_i); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (!s_axi_bvalid) @(posedge mclk_i);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge mclk_i);
    got = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(n, got, e);
  endtask
  // one character; the wait covers capture and store before any read
  task automatic put(input logic [7:0] b, input logic p, input logic s);
    @(posedge mclk_i);
    send <= 1'b1;
    tb <= b;
    bp <= p;
    bs <= s;
    @(posedge mclk_i);
    send <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    fails++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rc("lsr", OFF_LINE_STATUS, 32'h0);
    rc("ctrl", OFF_RX_CTRL, 32'h0);
    rc("unmapped", 8'h14, 32'h0);
    chk("rresp", resp, RESP_SLVERR);
    wr(8'h14, 32'h0);
    chk("bresp", resp, RESP_SLVERR);
    $display("test reset done");
    // holding register mode: depth one, second character overruns
    put(8'ha5, 1'b0, 1'b0);
    rc("lsr", OFF_LINE_STATUS, 32'h1);
    put(8'h5a, 1'b0, 1'b0);
    rc("lsr", OFF_LINE_STATUS, 32'h3);
    rc("data", OFF_RX_DATA, 32'ha5);
    rc("lsr", OFF_LINE_STATUS, 32'h0);
    put(8'h3c, 1'b0, 1'b1);
    wr(OFF_LINE_STATUS, 32'hff);
    chk("bresp", resp, RESP_OKAY);
    rc("lsr", OFF_LINE_STATUS, 32'h9);
    rc("data", OFF_RX_DATA, 32'h3c);
    $display("test holding done");
    // fifo mode, odd parity: fill, overrun once, drain with per-character tags
    wr(OFF_RX_CTRL, 32'h3);
    for (i = 0; i < 33; i++) put(8'(i + 16), i == 1, i == 2);
    rc("lsr", OFF_LINE_STATUS, 32'h3);
    for (i = 0; i < 32; i++) begin
      rc("lsr", OFF_LINE_STATUS, {28'h0, i == 2, i == 1, 2'h1});
      rc("data", OFF_RX_DATA, 32'(i + 16));
    end
    rc("lsr", OFF_LINE_STATUS, 32'h0);
    $display("test fifo done");
    // interrupt: raised, masked, cleared
    rc("int", OFF_INT_STATUS, 32'hf);
    chk("irq", irq_o, 32'h0);
    wr(OFF_INT_MASK, 32'h2);
    chk("irq", irq_o, 32'h1);
    wr(OFF_INT_STATUS, 32'h2);
    chk("irq", irq_o, 32'h0);
    rc("int", OFF_INT_STATUS, 32'hd);
    $display("test interrupt done");
    // even parity in fifo mode, then a mode switch flushes the store
    wr(OFF_RX_CTRL, 32'h7);
    put(8'h81, 1'b1, 1'b0);
    put(8'h81, 1'b0, 1'b0);
    rc("lsr", OFF_LINE_STATUS, 32'h1);
    rc("data", OFF_RX_DATA, 32'h81);
    rc("lsr", OFF_LINE_STATUS, 32'h5);
    wr(OFF_RX_CTRL, 32'h6);
    rc("ctrl", OFF_RX_CTRL, 32'h6);
    rc("lsr", OFF_LINE_STATUS, 32'h0);
    $display("test parity done");
    conclude();
  end
endmodule
`default_nettype wire
